// [bench/cdrcfg_tb.sv]
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wr_en_i = 1'b0;
	logic rd_en_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdata_o;
	logic rvalid_o;
	cdrcfg_pkg::cdrcfg_ctrl_t ctrl_o;
	int mismatches = 0;
	int cmp_count = 0;
	int i;
	logic [1:0] s;

	cdrcfg_regs cdrcfg_regs_inst (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.wr_en_i(wr_en_i),
		.rd_en_i(rd_en_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.rdata_o(rdata_o),
		.rvalid_o(rvalid_o),
		.ctrl_o(ctrl_o)
	);

	////////////////////////////////////////////////////////////////
	// Clock, 5 ns period
	initial
	begin
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	////////////////////////////////////////////////////////////////
	// Verdict and compare helpers
	task automatic close_out();
		if (mismatches == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Drive 1 ns after the edge so sampling never races the bench
	task automatic step();
		@(posedge ref_clk_i);
		#1;
	endtask

	// Decoded outputs lag a write by two edges
	task automatic settle();
		repeat (2) step();
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		step();
		wr_en_i = 1'b1;
		addr_i = a;
		wdata_i = d;
		step();
		wr_en_i = 1'b0;
	endtask

	// Answer stands one cycle only, so look right after the taking edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		step();
		rd_en_i = 1'b1;
		addr_i = a;
		step();
		rd_en_i = 1'b0;
		chk({7'h00, rvalid_o}, 8'h01);
		chk(rdata_o, exp);
	endtask

	////////////////////////////////////////////////////////////////
	// Watchdog, far beyond the hundred or fewer cycles the tests need
	initial
	begin
		repeat (3000) @(posedge ref_clk_i);
		mismatches++;
		close_out();
	end

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (6) @(posedge ref_clk_i);
		#1;
		rst_i = 1'b0;
		step();
		// Reset contents and decoded defaults
		rd(cdrcfg_pkg::ADDR_LOOP_EDGE_BW, 8'h04);
		rd(cdrcfg_pkg::ADDR_LOOP_THR_SLEW, 8'h00);
		rd(cdrcfg_pkg::ADDR_SAMPLE_OFS, 8'h00);
		rd(cdrcfg_pkg::ADDR_INPUT_STAGE, 8'h00);
		chk({5'h00, ctrl_o.transfer_bw_scale}, 8'h04);
		chk({6'h00, ctrl_o.rise_en, ctrl_o.fall_en}, 8'h03);
		// Every edge code with a different scale each time
		for (i = 0; i < 4; i++)
		begin
			wr(cdrcfg_pkg::ADDR_LOOP_EDGE_BW, 8'(i * 9 + 3));
			settle();
			chk({6'h00, ctrl_o.rise_en, ctrl_o.fall_en}, (i == 1) ? 8'h02 : (i == 2) ? 8'h01 : 8'h03);
			chk({5'h00, ctrl_o.transfer_bw_scale}, 8'(i + 3));
		end
		// Reserved bits must not stick
		wr(cdrcfg_pkg::ADDR_LOOP_EDGE_BW, 8'hFF);
		rd(cdrcfg_pkg::ADDR_LOOP_EDGE_BW, 8'h1F);
		// Unmapped place: write ignored, read zero
		wr(8'h11, 8'hAA);
		rd(8'h11, 8'h00);
		rd(cdrcfg_pkg::ADDR_LOOP_EDGE_BW, 8'h1F);
		// Auto threshold and slew, both levels
		wr(cdrcfg_pkg::ADDR_LOOP_THR_SLEW, 8'hFE);
		settle();
		rd(cdrcfg_pkg::ADDR_LOOP_THR_SLEW, 8'h06);
		chk({5'h00, ctrl_o.auto_threshold_enable, ctrl_o.dll_slew}, 8'h06);
		wr(cdrcfg_pkg::ADDR_LOOP_THR_SLEW, 8'h01);
		settle();
		chk({5'h00, ctrl_o.auto_threshold_enable, ctrl_o.dll_slew}, 8'h01);
		// Most negative phase, then most positive
		wr(cdrcfg_pkg::ADDR_SAMPLE_OFS, 8'hF8);
		settle();
		rd(cdrcfg_pkg::ADDR_SAMPLE_OFS, 8'h08);
		chk({4'h0, ctrl_o.sample_phase}, 8'h08);
		wr(cdrcfg_pkg::ADDR_SAMPLE_OFS, 8'h07);
		settle();
		chk({4'h0, ctrl_o.sample_phase}, 8'h07);
		// Extended range with an all-zero word, then a live word
		wr(cdrcfg_pkg::ADDR_DECISION_THR, 8'h80);
		settle();
		chk({ctrl_o.extended_range, ctrl_o.threshold}, 8'h80);
		chk({7'h00, ctrl_o.threshold_enable}, 8'h00);
		wr(cdrcfg_pkg::ADDR_DECISION_THR, 8'h05);
		settle();
		chk({ctrl_o.extended_range, ctrl_o.threshold}, 8'h05);
		chk({7'h00, ctrl_o.threshold_enable}, 8'h01);
		// All stage codes; the undefined one falls back to the amplifier
		for (i = 0; i < 4; i++)
		begin
			s = 2'(i);
			wr(cdrcfg_pkg::ADDR_INPUT_STAGE, {s[0], s, ~s[0], 2'b10, s});
			settle();
			rd(cdrcfg_pkg::ADDR_INPUT_STAGE, {s[0], s, ~s[0], 2'b10, s});
			chk({ctrl_o.term_float, ctrl_o.input_select, ctrl_o.auto_equalizer_enable, ctrl_o.equalizer_gain},
				{s[0], (s == 2'h3) ? 2'h0 : s, ~s[0], 2'b10, s});
			chk({7'h00, ctrl_o.manual_gain_valid}, {7'h00, s[0]});
		end
		close_out();
	end
endmodule

// [rtl/cdrcfg_decode.sv]
// Turns raw register bytes into named front-end controls
module cdrcfg_decode (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] edge_bw_i,
	input wire logic [7:0] thr_slew_i,
	input wire logic [7:0] sample_i,
	input wire logic [7:0] decision_i,
	input wire logic [7:0] stage_i,
	output cdrcfg_pkg::cdrcfg_ctrl_t ctrl_o
);

	cdrcfg_pkg::cdrcfg_ctrl_t ctrl_nxt;

	// Field decode
	always_comb
	begin
		ctrl_nxt = '0;
		ctrl_nxt.rise_en = (edge_bw_i[4:3] != cdrcfg_pkg::EDGE_FALL);
		ctrl_nxt.fall_en = (edge_bw_i[4:3] != cdrcfg_pkg::EDGE_RISE);
		ctrl_nxt.transfer_bw_scale = edge_bw_i[2:0];
		ctrl_nxt.auto_threshold_enable = thr_slew_i[2];
		ctrl_nxt.dll_slew = thr_slew_i[1:0];
		ctrl_nxt.sample_phase = signed'(sample_i[3:0]);
		ctrl_nxt.extended_range = decision_i[7];
		ctrl_nxt.threshold = decision_i[6:0];
		ctrl_nxt.threshold_enable = (decision_i[6:0] != cdrcfg_pkg::THR_OFF);
		ctrl_nxt.term_float = stage_i[7];
		// front end select; undefined code held at amplifier
		unique case (stage_i[6:5])
			cdrcfg_pkg::STAGE_LIMAMP: ctrl_nxt.input_select = cdrcfg_pkg::CDRCFG_SEL_LIMAMP;
			cdrcfg_pkg::STAGE_EQ: ctrl_nxt.input_select = cdrcfg_pkg::CDRCFG_SEL_EQ;
			cdrcfg_pkg::STAGE_BUF: ctrl_nxt.input_select = cdrcfg_pkg::CDRCFG_SEL_BUF;
			default: ctrl_nxt.input_select = cdrcfg_pkg::CDRCFG_SEL_LIMAMP;
		endcase
		ctrl_nxt.auto_equalizer_enable = stage_i[4];
		// manual gain applies only without adaptation
		ctrl_nxt.equalizer_gain = stage_i[3:0];
		ctrl_nxt.manual_gain_valid = ~stage_i[4];
	end

	// Registered controls keep glitches off the analogue side
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			ctrl_o <= '0;
		else
			ctrl_o <= ctrl_nxt;
	end

endmodule

// [rtl/cdrcfg_pkg.sv]
package cdrcfg_pkg;

	// Register offsets on the serial register port
	localparam logic [7:0] ADDR_LOOP_EDGE_BW = 8'h10;
	localparam logic [7:0] ADDR_LOOP_THR_SLEW = 8'h13;
	localparam logic [7:0] ADDR_SAMPLE_OFS = 8'h14;
	localparam logic [7:0] ADDR_DECISION_THR = 8'h15;
	localparam logic [7:0] ADDR_INPUT_STAGE = 8'h16;

	// Writable bit masks; reserved positions read zero
	localparam logic [7:0] MASK_LOOP_EDGE_BW = 8'h1F;
	localparam logic [7:0] MASK_LOOP_THR_SLEW = 8'h07;
	localparam logic [7:0] MASK_SAMPLE_OFS = 8'h0F;
	localparam logic [7:0] MASK_DECISION_THR = 8'hFF;
	localparam logic [7:0] MASK_INPUT_STAGE = 8'hFF;

	// Reset values
	localparam logic [7:0] RST_LOOP_EDGE_BW = 8'h04;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// Field values
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] STAGE_LIMAMP = 2'h0;
	localparam logic [1:0] STAGE_EQ = 2'h1;
	localparam logic [1:0] STAGE_BUF = 2'h2;
	localparam logic [6:0] THR_OFF = 7'h00;

	// Register index space
	localparam int NREG = 5;
	localparam logic [2:0] IDX_NONE = 3'h7;

	typedef enum logic [1:0]
	{
		CDRCFG_SEL_LIMAMP = 2'b00,
		CDRCFG_SEL_EQ = 2'b01,
		CDRCFG_SEL_BUF = 2'b10
	} cdrcfg_stage_t;

	// Decoded controls towards the analogue loop and front end
	typedef struct packed
	{
		logic rise_en;
		logic fall_en;
		logic [2:0] transfer_bw_scale;
		logic auto_threshold_enable;
		logic [1:0] dll_slew;
		logic signed [3:0] sample_phase;
		logic extended_range;
		logic [6:0] threshold;
		logic threshold_enable;
		logic term_float;
		cdrcfg_stage_t input_select;
		logic auto_equalizer_enable;
		logic [3:0] equalizer_gain;
		logic manual_gain_valid;
	} cdrcfg_ctrl_t;

endpackage

// [rtl/cdrcfg_regfile.sv]
// Five byte registers with per-register writable masks
module cdrcfg_regfile #(
	parameter int NREG = 5
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic wr_en_i,
	input wire logic [2:0] wr_idx_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [2:0] rd_idx_i,
	input wire logic [7:0] mask_i [NREG],
	input wire logic [7:0] rst_val_i [NREG],
	output logic [7:0] regs_o [NREG],
	output logic [7:0] rd_data_o
);

	genvar g;
	generate
		for (g = 0; g < NREG; g++)
		begin : g_reg
			// Masked store keeps reserved bits at zero
			always_ff @(posedge ref_clk_i)
			begin
				if (rst_i)
					regs_o[g] <= rst_val_i[g];
				else if (wr_en_i && wr_idx_i == 3'(g))
					regs_o[g] <= wr_data_i & mask_i[g];
			end
		end
	endgenerate

	// Registered read data; unmapped index reads zero
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			rd_data_o <= 8'h00;
		else if (rd_idx_i < 3'(NREG))
			rd_data_o <= regs_o[rd_idx_i];
		else
			rd_data_o <= 8'h00;
	end

endmodule

// [rtl/cdrcfg_regs.sv]
module cdrcfg_regs (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	output cdrcfg_pkg::cdrcfg_ctrl_t ctrl_o
);

	////////////////////////////////////////////////////////////////
	// Address decode

	// Maps a bus address to a register index, shared by read and write
	function automatic logic [2:0] addr_to_idx(input logic [7:0] a);
		unique case (a)
			cdrcfg_pkg::ADDR_LOOP_EDGE_BW: addr_to_idx = 3'h0;
			cdrcfg_pkg::ADDR_LOOP_THR_SLEW: addr_to_idx = 3'h1;
			cdrcfg_pkg::ADDR_SAMPLE_OFS: addr_to_idx = 3'h2;
			cdrcfg_pkg::ADDR_DECISION_THR: addr_to_idx = 3'h3;
			cdrcfg_pkg::ADDR_INPUT_STAGE: addr_to_idx = 3'h4;
			default: addr_to_idx = cdrcfg_pkg::IDX_NONE;
		endcase
	endfunction

	logic [2:0] idx;
	logic [7:0] masks [cdrcfg_pkg::NREG];
	logic [7:0] rst_vals [cdrcfg_pkg::NREG];
	logic [7:0] regs [cdrcfg_pkg::NREG];
	logic rvalid_r;

	assign idx = addr_to_idx(addr_i);

	assign masks[0] = cdrcfg_pkg::MASK_LOOP_EDGE_BW;
	assign masks[1] = cdrcfg_pkg::MASK_LOOP_THR_SLEW;
	assign masks[2] = cdrcfg_pkg::MASK_SAMPLE_OFS;
	assign masks[3] = cdrcfg_pkg::MASK_DECISION_THR;
	assign masks[4] = cdrcfg_pkg::MASK_INPUT_STAGE;

	assign rst_vals[0] = cdrcfg_pkg::RST_LOOP_EDGE_BW;
	assign rst_vals[1] = cdrcfg_pkg::RST_ZERO;
	assign rst_vals[2] = cdrcfg_pkg::RST_ZERO;
	assign rst_vals[3] = cdrcfg_pkg::RST_ZERO;
	assign rst_vals[4] = cdrcfg_pkg::RST_ZERO;

	////////////////////////////////////////////////////////////////
	// Storage and decode

	cdrcfg_regfile #(
		.NREG(cdrcfg_pkg::NREG)
	) u_file (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.wr_en_i(wr_en_i),
		.wr_idx_i(idx),
		.wr_data_i(wdata_i),
		.rd_idx_i(idx),
		.mask_i(masks),
		.rst_val_i(rst_vals),
		.regs_o(regs),
		.rd_data_o(rdata_o)
	);

	cdrcfg_decode u_dec (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.edge_bw_i(regs[0]),
		.thr_slew_i(regs[1]),
		.sample_i(regs[2]),
		.decision_i(regs[3]),
		.stage_i(regs[4]),
		.ctrl_o(ctrl_o)
	);

	// Read answer one cycle after the request, like the data
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			rvalid_r <= 1'b0;
		else
			rvalid_r <= rd_en_i;
	end
	assign rvalid_o = rvalid_r;

	////////////////////////////////////////////////////////////////
	// Checks

	a_bw_reset: assert property (@(posedge ref_clk_i) $fell(rst_i) |-> ##1 ctrl_o.transfer_bw_scale == 3'h4)
		else $error("bandwidth scale not four after reset");
	a_edge_both: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(regs[0][4] == regs[0][3]) |=> (ctrl_o.rise_en && ctrl_o.fall_en))
		else $error("both-edge code did not enable both edges");
	a_edge_single: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(regs[0][4:3] == 2'h1) |=> (ctrl_o.rise_en && !ctrl_o.fall_en))
		else $error("rising-only code wrong");
	a_rsvd_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(rd_en_i && addr_i == cdrcfg_pkg::ADDR_SAMPLE_OFS) |=> rdata_o[7:4] == 4'h0)
		else $error("reserved bits read nonzero");
	a_thr_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(regs[3][6:0] == 7'h00) |=> !ctrl_o.threshold_enable)
		else $error("zero threshold not disabled");
	// write reaches threshold mode in two cycles
	a_auto_thr: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(wr_en_i && addr_i == cdrcfg_pkg::ADDR_LOOP_THR_SLEW) |-> ##2 ctrl_o.auto_threshold_enable == $past(wdata_i[2], 2))
		else $error("auto threshold bit not applied");
	a_phase_wr: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(wr_en_i && addr_i == cdrcfg_pkg::ADDR_SAMPLE_OFS) |-> ##2 ctrl_o.sample_phase == $past(wdata_i[3:0], 2))
		else $error("sample phase not applied");
	a_stage_buf: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(regs[4][6:5] == 2'h2) |=> ctrl_o.input_select == cdrcfg_pkg::CDRCFG_SEL_BUF)
		else $error("buffer stage not selected");
	// manual gain validity is the inverse of adaptation bit
	a_eq_manual: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		1'b1 |=> ctrl_o.manual_gain_valid != ctrl_o.auto_equalizer_enable)
		else $error("manual gain validity wrong");
	a_term: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		1'b1 |=> ctrl_o.term_float == $past(regs[4][7]))
		else $error("termination float mismatch");

	c_write_stage: cover property (@(posedge ref_clk_i) wr_en_i && addr_i == cdrcfg_pkg::ADDR_INPUT_STAGE);
	c_read_thr: cover property (@(posedge ref_clk_i) rd_en_i && addr_i == cdrcfg_pkg::ADDR_DECISION_THR ##1 rvalid_o);
	c_ext_range: cover property (@(posedge ref_clk_i) ctrl_o.extended_range && ctrl_o.threshold_enable);

endmodule
